/* include/playback_path_regs.vh */
`ifndef PLAYBACK_PATH_REGS_VH
`define PLAYBACK_PATH_REGS_VH

// ********************************************
// register indices (byte address = index * 4)
// ********************************************
`define SRC_LEVEL_IDX        8'h03
`define HIGHPASS_IDX         8'h04
`define PCM_VOLUME_IDX       8'h05

// ********************************************
// reset values
// ********************************************
`define SRC_LEVEL_RESET      8'h10
`define HIGHPASS_RESET       8'h01
`define PCM_VOLUME_RESET     8'h00

// ********************************************
// field positions
// ********************************************
`define PDM_PIN_ROLE_BIT     7
`define PDM_PB_SELECT_BIT    6
`define PB_SOURCE_BIT        5
`define AMP_LEVEL_MSB        4
`define AMP_LEVEL_LSB        0
`define HPF_CORNER_MSB       2
`define HPF_CORNER_LSB       0

// ********************************************
// field encodings
// ********************************************
`define AMP_LEVEL_MAX_CODE   5'h13
`define AMP_LEVEL_BASE_HALF  8'h16
`define HPF_BYPASS           3'h0
`define HPF_RESERVED         3'h7
`define HPF_HZ_2             10'h002
`define HPF_HZ_50            10'h032
`define HPF_HZ_100           10'h064
`define HPF_HZ_200           10'h0C8
`define HPF_HZ_400           10'h190
`define HPF_HZ_800           10'h320
`define PCM_VOL_MAX_ATTEN    8'hC8
`define RAMP_RATE_1          2'h0
`define RAMP_RATE_4          2'h1
`define RAMP_RATE_8          2'h2
`define RAMP_RATE_OFF        2'h3
`define RAMP_SAMPLES_1       4'h1
`define RAMP_SAMPLES_4       4'h4
`define RAMP_SAMPLES_8       4'h8

// ********************************************
// bus encodings
// ********************************************
`define HSIZE_WORD           3'h2
`define HRESP_OKAY           1'b0

`endif

/* hdl/ahb_word_slave.v */
`timescale 1ns/1ps
`include "playback_path_regs.vh"

module ahb_word_slave (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        clk_en_i,
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output wire        hreadyout_o,
	output wire        hresp_o,
	output wire [31:0] hrdata_o,
	output wire [7:0]  rd_idx_o,
	input  wire        rd_hit_i,
	input  wire [7:0]  rd_value_i,
	output wire        wr_en_o,
	output wire [7:0]  wr_idx_o,
	output wire [7:0]  wr_data_o
);

	reg         wr_pend_reg;
	reg  [7:0]  wr_idx_reg;
	reg  [31:0] hrdata_reg;
	wire        take;
	wire        word_ok;
	wire        fwd;

	// stall the master while the block is frozen
	assign hreadyout_o = clk_en_i;
	assign hresp_o     = `HRESP_OKAY;
	assign hrdata_o    = hrdata_reg;
	assign rd_idx_o    = {2'h0, haddr_i[7:2]};
	assign take        = clk_en_i & hsel_i & htrans_i[1] & hready_i;
	assign word_ok     = (hsize_i == `HSIZE_WORD) & (haddr_i[1:0] == 2'h0) & (haddr_i[31:8] == 24'h0);
	// a read right behind a write to the same register sees the new data
	assign fwd         = wr_pend_reg & (wr_idx_reg == rd_idx_o);
	assign wr_en_o     = wr_pend_reg & clk_en_i;
	assign wr_idx_o    = wr_idx_reg;
	assign wr_data_o   = hwdata_i[7:0];

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
		end else if (clk_en_i) begin
			wr_pend_reg <= take & hwrite_i & word_ok & rd_hit_i;
			if (take) begin
				wr_idx_reg <= rd_idx_o;
			end
			if (take & ~hwrite_i) begin
				if (!(word_ok & rd_hit_i)) begin
					hrdata_reg <= 32'h0000_0000;
				end else if (fwd) begin
					hrdata_reg <= {24'h00_0000, hwdata_i[7:0]};
				end else begin
					hrdata_reg <= {24'h00_0000, rd_value_i};
				end
			end
		end
	end

endmodule

/* hdl/volume_ramp.v */
`timescale 1ns/1ps
`include "playback_path_regs.vh"

module volume_ramp #(
	parameter WIDTH = 8
) (
	input  wire             clk_i,
	input  wire             rst_n_i,
	input  wire             clk_en_i,
	input  wire [WIDTH-1:0] target_i,
	input  wire [1:0]       rate_i,
	input  wire             sample_i,
	output wire [WIDTH-1:0] current_o,
	output wire             busy_o
);

	reg  [WIDTH-1:0] current_reg;
	reg  [3:0]       count_reg;
	reg  [3:0]       period;
	wire             step;

	always @* begin
		case (rate_i)
			`RAMP_RATE_1: period = `RAMP_SAMPLES_1;
			`RAMP_RATE_4: period = `RAMP_SAMPLES_4;
			`RAMP_RATE_8: period = `RAMP_SAMPLES_8;
			default:      period = `RAMP_SAMPLES_1;
		endcase
	end

	assign step      = sample_i & (count_reg + 4'h1 >= period);
	assign current_o = current_reg;
	assign busy_o    = (current_reg != target_i);

	// one 0.5 dB code per period of samples; ramp off jumps straight to target
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			current_reg <= {WIDTH{1'b0}};
			count_reg   <= 4'h0;
		end else if (clk_en_i) begin
			if (rate_i == `RAMP_RATE_OFF) begin
				current_reg <= target_i;
				count_reg   <= 4'h0;
			end else if (!busy_o) begin
				count_reg <= 4'h0;
			end else if (sample_i) begin
				if (step) begin
					count_reg <= 4'h0;
					if (current_reg < target_i) begin
						current_reg <= current_reg + {{(WIDTH-1){1'b0}}, 1'b1};
					end else begin
						current_reg <= current_reg - {{(WIDTH-1){1'b0}}, 1'b1};
					end
				end else begin
					count_reg <= count_reg + 4'h1;
				end
			end
		end
	end

endmodule

/* hdl/playback_path_config_regs.v */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "playback_path_regs.vh"

module playback_path_config_regs (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        clk_en_i,
	// ********************************************
	// AHB-Lite slave
	// ********************************************
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output wire        hreadyout_o,
	output wire        hresp_o,
	output wire [31:0] hrdata_o,
	// ********************************************
	// playback path side
	// ********************************************
	input  wire [1:0]  volume_ramp_rate_i,
	input  wire        sample_strobe_i,
	output wire        pdm_pin_role_o,
	output wire        pdm_playback_select_o,
	output wire        playback_source_select_o,
	output wire        pdm_input_one_to_playback_o,
	output wire        pdm_input_one_to_sensor_o,
	output wire        pdm_playback_enable_o,
	output wire        pcm_playback_enable_o,
	output wire [4:0]  amp_level_code_o,
	output wire [7:0]  amp_level_half_dbv_o,
	output wire        amp_level_code_reserved_o,
	output wire [2:0]  highpass_corner_select_o,
	output wire        highpass_enable_o,
	output wire [9:0]  highpass_corner_hz_o,
	output wire [7:0]  pcm_volume_code_o,
	output wire [7:0]  pcm_atten_half_db_o,
	output wire        pcm_mute_o,
	output wire        pcm_volume_ramping_o
);

	// ********************************************
	// storage
	// ********************************************
	reg  [7:0] src_level_reg;
	reg  [7:0] highpass_reg;
	reg  [7:0] pcm_volume_reg;

	reg        pdm_one_play_reg;
	reg        pdm_one_sensor_reg;
	reg        pdm_play_en_reg;
	reg        pcm_play_en_reg;
	reg  [7:0] amp_half_dbv_reg;
	reg        amp_reserved_reg;
	reg        hpf_en_reg;
	reg  [9:0] hpf_hz_reg;
	reg  [7:0] atten_reg;
	reg        mute_reg;

	reg  [7:0] amp_half_dbv_next;
	reg        hpf_en_next;
	reg  [9:0] hpf_hz_next;
	reg  [7:0] rd_value;
	reg        rd_hit;

	wire [7:0] rd_idx;
	wire       wr_en;
	wire [7:0] wr_idx;
	wire [7:0] wr_data;
	wire [7:0] ramp_current;
	wire       ramp_busy;

	wire       pdm_role_play;
	wire       pdm_sel;
	wire       src_is_pdm;
	wire [4:0] amp_code;
	wire [2:0] hpf_code;
	wire       amp_code_legal;
	wire       pdm_route_ok;
	wire       vol_past_floor;

	// ********************************************
	// bus front end
	// ********************************************
	ahb_word_slave u_bus (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.clk_en_i    (clk_en_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hsize_i     (hsize_i),
		.hwdata_i    (hwdata_i),
		.hready_i    (hready_i),
		.hreadyout_o (hreadyout_o),
		.hresp_o     (hresp_o),
		.hrdata_o    (hrdata_o),
		.rd_idx_o    (rd_idx),
		.rd_hit_i    (rd_hit),
		.rd_value_i  (rd_value),
		.wr_en_o     (wr_en),
		.wr_idx_o    (wr_idx),
		.wr_data_o   (wr_data)
	);

	// ********************************************
	// read decode
	// ********************************************
	always @* begin
		rd_hit   = 1'b1;
		rd_value = 8'h00;
		case (rd_idx)
			`SRC_LEVEL_IDX:  rd_value = src_level_reg;
			`HIGHPASS_IDX:   rd_value = highpass_reg;
			`PCM_VOLUME_IDX: rd_value = pcm_volume_reg;
			default:         rd_hit   = 1'b0;
		endcase
	end

	// ********************************************
	// register writes
	// ********************************************
	// all eight bits are kept so reserved bits read back what was written
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_level_reg  <= `SRC_LEVEL_RESET;
			highpass_reg   <= `HIGHPASS_RESET;
			pcm_volume_reg <= `PCM_VOLUME_RESET;
		end else if (clk_en_i && wr_en) begin
			case (wr_idx)
				`SRC_LEVEL_IDX:  src_level_reg  <= wr_data;
				`HIGHPASS_IDX:   highpass_reg   <= wr_data;
				`PCM_VOLUME_IDX: pcm_volume_reg <= wr_data;
				default:         src_level_reg  <= src_level_reg;
			endcase
		end
	end

	// ********************************************
	// field decode
	// ********************************************
	assign pdm_role_play = src_level_reg[`PDM_PIN_ROLE_BIT];
	assign pdm_sel       = src_level_reg[`PDM_PB_SELECT_BIT];
	assign src_is_pdm    = src_level_reg[`PB_SOURCE_BIT];
	assign amp_code      = src_level_reg[`AMP_LEVEL_MSB:`AMP_LEVEL_LSB];
	assign hpf_code      = highpass_reg[`HPF_CORNER_MSB:`HPF_CORNER_LSB];

	assign pdm_pin_role_o           = pdm_role_play;
	assign pdm_playback_select_o    = pdm_sel;
	assign playback_source_select_o = src_is_pdm;
	assign amp_level_code_o         = amp_code;
	assign highpass_corner_select_o = hpf_code;
	assign pcm_volume_code_o        = pcm_volume_reg;

	// ********************************************
	// derived conditions
	// ********************************************
	assign amp_code_legal = (amp_code <= `AMP_LEVEL_MAX_CODE);
	// the reserved selector value never routes PDM audio
	assign pdm_route_ok   = pdm_role_play & ~pdm_sel;
	assign vol_past_floor = (ramp_current > `PCM_VOL_MAX_ATTEN);

	// amp level: a code outside the table keeps the last legal level
	always @* begin
		if (amp_code_legal) begin
			amp_half_dbv_next = `AMP_LEVEL_BASE_HALF + {3'h0, amp_code};
		end else begin
			amp_half_dbv_next = amp_half_dbv_reg;
		end
	end

	// high-pass corner, only meaningful while PCM plays
	always @* begin
		hpf_en_next = ~src_is_pdm;
		case (hpf_code)
			3'h1:    hpf_hz_next = `HPF_HZ_2;
			3'h2:    hpf_hz_next = `HPF_HZ_50;
			3'h3:    hpf_hz_next = `HPF_HZ_100;
			3'h4:    hpf_hz_next = `HPF_HZ_200;
			3'h5:    hpf_hz_next = `HPF_HZ_400;
			3'h6:    hpf_hz_next = `HPF_HZ_800;
			default: begin
				// bypass and the reserved code both leave the filter out
				hpf_hz_next = 10'h000;
				hpf_en_next = 1'b0;
			end
		endcase
	end

	// ********************************************
	// PCM volume ramp
	// ********************************************
	// only the PCM code is ramped here; rate and sample timing come from outside
	volume_ramp #(
		.WIDTH (8)
	) u_ramp (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.clk_en_i  (clk_en_i),
		.target_i  (pcm_volume_reg),
		.rate_i    (volume_ramp_rate_i),
		.sample_i  (sample_strobe_i),
		.current_o (ramp_current),
		.busy_o    (ramp_busy)
	);

	// ********************************************
	// registered PDM routing
	// ********************************************
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pdm_one_play_reg   <= 1'b0;
			pdm_one_sensor_reg <= 1'b1;
			pdm_play_en_reg    <= 1'b0;
			pcm_play_en_reg    <= 1'b1;
		end else if (clk_en_i) begin
			pdm_one_play_reg   <= pdm_role_play;
			pdm_one_sensor_reg <= ~pdm_role_play;
			pdm_play_en_reg    <= src_is_pdm & pdm_route_ok;
			pcm_play_en_reg    <= ~src_is_pdm;
		end
	end

	// ********************************************
	// registered amplifier level
	// ********************************************
	// the flag lets software see a reserved code parked in the field
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			amp_half_dbv_reg <= `AMP_LEVEL_BASE_HALF + (`SRC_LEVEL_RESET & 8'h1F);
			amp_reserved_reg <= 1'b0;
		end else if (clk_en_i) begin
			amp_half_dbv_reg <= amp_half_dbv_next;
			amp_reserved_reg <= ~amp_code_legal;
		end
	end

	// ********************************************
	// registered high-pass setting
	// ********************************************
	// a new corner follows the field on the next edge, no reset needed
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hpf_en_reg <= 1'b1;
			hpf_hz_reg <= `HPF_HZ_2;
		end else if (clk_en_i) begin
			hpf_en_reg <= hpf_en_next;
			hpf_hz_reg <= hpf_hz_next;
		end
	end

	// ********************************************
	// registered PCM attenuation
	// ********************************************
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			atten_reg <= `PCM_VOLUME_RESET;
			mute_reg  <= 1'b0;
		end else if (clk_en_i) begin
			// codes past the deepest step are held at -100 dB and muted
			if (vol_past_floor) begin
				atten_reg <= `PCM_VOL_MAX_ATTEN;
				mute_reg  <= 1'b1;
			end else begin
				atten_reg <= ramp_current;
				mute_reg  <= 1'b0;
			end
		end
	end

	// ********************************************
	// outputs
	// ********************************************
	assign pdm_input_one_to_playback_o = pdm_one_play_reg;
	assign pdm_input_one_to_sensor_o   = pdm_one_sensor_reg;
	assign pdm_playback_enable_o       = pdm_play_en_reg;
	assign pcm_playback_enable_o       = pcm_play_en_reg;
	assign amp_level_half_dbv_o        = amp_half_dbv_reg;
	assign amp_level_code_reserved_o   = amp_reserved_reg;
	assign highpass_enable_o           = hpf_en_reg;
	assign highpass_corner_hz_o        = hpf_hz_reg;
	assign pcm_atten_half_db_o         = atten_reg;
	assign pcm_mute_o                  = mute_reg;
	assign pcm_volume_ramping_o        = ramp_busy;

endmodule

/* bench/playback_path_asserts.sv */
`timescale 1ns/1ps

module playback_path_asserts (
	input wire        clk_i,
	input wire        rst_n_i,
	input wire        hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0]  htrans_i,
	input wire        hwrite_i,
	input wire [31:0] hwdata_i,
	input wire        hready_i,
	input wire        pdm_pin_role_o,
	input wire        pdm_playback_select_o,
	input wire        playback_source_select_o,
	input wire        pdm_input_one_to_playback_o,
	input wire        pdm_input_one_to_sensor_o,
	input wire        pdm_playback_enable_o,
	input wire        pcm_playback_enable_o,
	input wire [4:0]  amp_level_code_o,
	input wire [7:0]  amp_level_half_dbv_o,
	input wire        amp_level_code_reserved_o,
	input wire [2:0]  highpass_corner_select_o,
	input wire        highpass_enable_o,
	input wire [9:0]  highpass_corner_hz_o,
	input wire [7:0]  pcm_volume_code_o,
	input wire [7:0]  pcm_atten_half_db_o,
	input wire        pcm_mute_o
);
	// ****
	// derived outputs against register fields
	// ****
	wire [7:0] wdata_low = hwdata_i[7:0];

	function automatic [9:0] corner_hz(input [2:0] c);
		case (c)
			3'h1: corner_hz = 10'h002;
			3'h2: corner_hz = 10'h032;
			3'h3: corner_hz = 10'h064;
			3'h4: corner_hz = 10'h0C8;
			3'h5: corner_hz = 10'h190;
			3'h6: corner_hz = 10'h320;
			default: corner_hz = 10'h000;
		endcase
	endfunction

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_vol_addr;
		hsel_i && htrans_i == 2'h2 && hwrite_i && hready_i && haddr_i == 32'h00000014;
	endsequence
	sequence s_vol_data;
		hready_i;
	endsequence

	chk_role_split:
	assert property (pdm_input_one_to_playback_o != pdm_input_one_to_sensor_o
		&& pdm_input_one_to_playback_o == $past(pdm_pin_role_o)) else $error("pin role outputs wrong");
	chk_pdm_route:
	assert property (pdm_playback_enable_o == $past(playback_source_select_o && pdm_pin_role_o
		&& !pdm_playback_select_o)) else $error("pdm playback enable wrong");
	chk_pcm_route:
	assert property (pcm_playback_enable_o == !$past(playback_source_select_o)) else $error("pcm enable wrong");
	chk_amp_scale:
	assert property ($past(amp_level_code_o) <= 5'h13 |->
		amp_level_half_dbv_o == 8'h16 + $past(amp_level_code_o)) else $error("amp level scale wrong");
	chk_amp_flag:
	assert property (amp_level_code_reserved_o == ($past(amp_level_code_o) > 5'h13)) else $error("amp flag wrong");
	chk_hpf_gate:
	assert property (highpass_enable_o == (!$past(playback_source_select_o)
		&& $past(highpass_corner_select_o) != 3'h0 && $past(highpass_corner_select_o) != 3'h7))
		else $error("highpass enable wrong");
	chk_hpf_corner:
	assert property (highpass_corner_hz_o == corner_hz($past(highpass_corner_select_o)))
		else $error("highpass corner wrong");
	chk_mute_clamp:
	assert property (pcm_mute_o |-> pcm_atten_half_db_o == 8'hC8) else $error("mute without clamp");
	chk_vol_write:
	assert property (s_vol_addr ##1 s_vol_data |=> pcm_volume_code_o == $past(wdata_low))
		else $error("volume write lost");
endmodule

/* bench/playback_path_config_regs_bench.sv */
`timescale 1ns/1ps
`include "playback_path_regs.vh"

module playback_path_config_regs_bench;
	// ****
	// stimulus and wiring
	// ****
	reg         clk_i    = 1'b0;
	reg         rst_n_i  = 1'b0;
	reg         hsel_i   = 1'b0;
	reg  [31:0] haddr_i  = 32'h0;
	reg  [1:0]  htrans_i = 2'h0;
	reg         hwrite_i = 1'b0;
	reg  [31:0] hwdata_i = 32'h0;
	reg  [1:0]  rate     = 2'h3;
	reg         strobe   = 1'b0;
	wire        hready, hresp, role, psel, src, to_pb, to_sn, pdm_en, pcm_en, amp_rsv, hpf_en, mute, ramping;
	wire [31:0] hrdata;
	wire [4:0]  amp_code;
	wire [7:0]  amp_half, vol_code, atten;
	wire [2:0]  hpf_sel;
	wire [9:0]  hpf_hz;
	integer     err_count, tests_run, seed, i, j;
	reg  [31:0] r;
	reg  [7:0]  d;
	reg  [1:0]  s;

	always #12.5 clk_i = ~clk_i;

	playback_path_config_regs playback_path_config_regs_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(`HSIZE_WORD), .hwdata_i(hwdata_i),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
		.volume_ramp_rate_i(rate), .sample_strobe_i(strobe), .pdm_pin_role_o(role),
		.pdm_playback_select_o(psel), .playback_source_select_o(src), .pdm_input_one_to_playback_o(to_pb),
		.pdm_input_one_to_sensor_o(to_sn), .pdm_playback_enable_o(pdm_en), .pcm_playback_enable_o(pcm_en),
		.amp_level_code_o(amp_code), .amp_level_half_dbv_o(amp_half), .amp_level_code_reserved_o(amp_rsv),
		.highpass_corner_select_o(hpf_sel), .highpass_enable_o(hpf_en), .highpass_corner_hz_o(hpf_hz),
		.pcm_volume_code_o(vol_code), .pcm_atten_half_db_o(atten), .pcm_mute_o(mute),
		.pcm_volume_ramping_o(ramping));

	// ****
	// bus tasks and expectations
	// ****
	task conclude;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	task check(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task idle(input integer n);
		repeat (n) @(posedge clk_i);
	endtask

	// bounded, so a stuck ready ends the run instead of hanging it
	task wait_ready;
		integer n;
		begin
			n = 0;
			@(posedge clk_i);
			while (hready !== 1'b1 && n < 50) begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (n >= 50) begin
				err_count = err_count + 1;
				$display("ERROR at %0t: bus wait ran out", $time);
				conclude;
			end
		end
	endtask

	// entered just after a rising edge, returns just after one: back to back transfers
	task bus(input wr, input [31:0] addr, input [31:0] wdata, output [31:0] rdata);
		begin
			hsel_i <= 1'b1;
			htrans_i <= 2'h2;
			haddr_i <= addr;
			hwrite_i <= wr;
			wait_ready;
			hsel_i <= 1'b0;
			htrans_i <= 2'h0;
			hwdata_i <= wdata;
			wait_ready;
			rdata = hrdata;
		end
	endtask

	task wr(input [31:0] addr, input [31:0] data);
		reg [31:0] unused;
		bus(1'b1, addr, data, unused);
	endtask

	task rd_check(input [31:0] addr, input [31:0] exp);
		reg [31:0] got;
		begin
			bus(1'b0, addr, 32'h0, got);
			check(got, exp);
		end
	endtask

	task pulse(input integer n);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1) begin
				strobe <= 1'b1;
				@(posedge clk_i);
				strobe <= 1'b0;
				@(posedge clk_i);
			end
			idle(2);
		end
	endtask

	function [31:0] addr_of(input [1:0] sel);
		case (sel)
			2'h0: addr_of = {22'h0, `SRC_LEVEL_IDX, 2'b00};
			2'h1: addr_of = {22'h0, `HIGHPASS_IDX, 2'b00};
			default: addr_of = {22'h0, `PCM_VOLUME_IDX, 2'b00};
		endcase
	endfunction

	function [9:0] hz_exp(input [2:0] c);
		case (c)
			3'h1: hz_exp = 10'h002;
			3'h2: hz_exp = 10'h032;
			3'h3: hz_exp = 10'h064;
			3'h4: hz_exp = 10'h0C8;
			3'h5: hz_exp = 10'h190;
			3'h6: hz_exp = 10'h320;
			default: hz_exp = 10'h000;
		endcase
	endfunction

	// ****
	// main sequence
	// ****
	initial begin
		err_count = 0;
		tests_run = 0;
		seed = 32'hD86A;
		idle(5);
		rst_n_i <= 1'b1;
		idle(1);
		rd_check(addr_of(0), 32'h10);
		rd_check(addr_of(1), 32'h01);
		rd_check(addr_of(2), 32'h00);
		check(hpf_hz, 10'h002);
		for (i = 0; i < 24; i = i + 1) begin
			r = $random(seed);
			s = r[9:8] % 3;
			d = r[7:0];
			if (s == 2'h0 && d[4:0] > 5'h13) d[4] = 1'b0;
			wr(addr_of(s), {r[31:8], d});
			rd_check(addr_of(s), {24'h0, d});
			check(hresp, 1'b0);
			if (s == 2'h0) begin
				check({role, psel, src, amp_code}, d);
				check(to_pb, d[7]);
				check(to_sn, !d[7]);
				check(pdm_en, d[5] & d[7] & ~d[6]);
				check(amp_half, 8'h16 + d[4:0]);
			end else if (s == 2'h1) begin
				check(hpf_sel, d[2:0]);
			end else begin
				check(vol_code, d);
			end
		end
		wr(32'h00000018, 32'hFF);
		rd_check(32'h00000018, 32'h0);
		// ramp still off: the ramped code jumps to zero, so the ramp walk starts from a known code
		wr(addr_of(2), 32'h00);
		for (i = 0; i < 2; i = i + 1) begin
			wr(addr_of(0), i ? 32'h33 : 32'h00);
			for (j = 0; j < 8; j = j + 1) begin
				wr(addr_of(1), j);
				idle(2);
				check(hpf_hz, hz_exp(j[2:0]));
				check(hpf_en, i == 0 && j != 0 && j != 7);
			end
			check(amp_half, i ? 8'h29 : 8'h16);
			check(pcm_en, i == 0);
		end
		check(atten, 8'h00);
		check(mute, 1'b0);
		wr(addr_of(0), 32'h14);
		idle(2);
		check(amp_rsv, 1'b1);
		check(amp_half, 8'h29);
		rate <= `RAMP_RATE_1;
		wr(addr_of(2), 32'h04);
		pulse(1);
		check(atten, 8'h01);
		check(ramping, 1'b1);
		pulse(3);
		check(atten, 8'h04);
		check(ramping, 1'b0);
		rate <= `RAMP_RATE_4;
		wr(addr_of(2), 32'h08);
		pulse(8);
		check(atten, 8'h06);
		rate <= `RAMP_RATE_8;
		wr(addr_of(2), 32'h0A);
		pulse(8);
		check(atten, 8'h07);
		rate <= `RAMP_RATE_OFF;
		wr(addr_of(2), 32'hFF);
		pulse(1);
		check(mute, 1'b1);
		check(atten, 8'hC8);
		wr(addr_of(2), 32'hC8);
		pulse(1);
		check(mute, 1'b0);
		check(atten, 8'hC8);
		conclude;
	end
endmodule

bind playback_path_config_regs playback_path_asserts playback_path_asserts_i (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .pdm_pin_role_o(pdm_pin_role_o),
	.pdm_playback_select_o(pdm_playback_select_o), .playback_source_select_o(playback_source_select_o),
	.pdm_input_one_to_playback_o(pdm_input_one_to_playback_o), .pdm_input_one_to_sensor_o(pdm_input_one_to_sensor_o),
	.pdm_playback_enable_o(pdm_playback_enable_o), .pcm_playback_enable_o(pcm_playback_enable_o),
	.amp_level_code_o(amp_level_code_o), .amp_level_half_dbv_o(amp_level_half_dbv_o),
	.amp_level_code_reserved_o(amp_level_code_reserved_o), .highpass_corner_select_o(highpass_corner_select_o),
	.highpass_enable_o(highpass_enable_o), .highpass_corner_hz_o(highpass_corner_hz_o),
	.pcm_volume_code_o(pcm_volume_code_o), .pcm_atten_half_db_o(pcm_atten_half_db_o), .pcm_mute_o(pcm_mute_o));
